// ==== design/ucg_baud_gen.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------
// baud down-counter: reloads at zero or on request, ticks at zero
// ----------------------------------------------------------------------
module ucg_baud_gen #(
    parameter int DIV_W = 12
) (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic [DIV_W-1:0] divisor, // reload value
    input wire logic reload, // forced reload pulse
    output logic tick, // one pulse per wrap through zero
    output logic [DIV_W-1:0] count // present counter value
);

    logic [DIV_W-1:0] next_count; // counter next value
    logic next_tick; // tick next value

    // count down, reload from divisor at zero or when forced
    always_comb
    begin
        next_tick = 1'b0;
        if (reload)
        begin
            next_count = divisor; // R5
        end
        else if (count == '0)
        begin
            next_count = divisor; // R5
            next_tick = 1'b1; // R6
        end
        else
        begin
            next_count = count - 1'b1;
        end
    end

    // register counter state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count <= '0;
            tick <= 1'b0;
        end
        else
        begin
            count <= next_count;
            tick <= next_tick;
        end
    end

endmodule
`default_nettype wire

// ==== design/ucg_clock_gen.sv ====
// Operation
// [R1] four clock modes: async, double, master, slave
// [R2] sync select bit: 0 async, 1 sync
// [R3] direction bit picks master or slave clock
// [R4] transfer clock pin idle in async modes
// [R5] counter reloads at zero and on low write
// [R6] one tick per wrap: fclk over divisor+1
// [R7] transmit tick divides baud by 16, 8, 2
// [R8] receiver phase machine of 16, 8, 2 states
// [R9] divisor twelve bits from high and low
// [R10] double speed ignored in synchronous modes
// [R11] software keeps double speed clear when sync
// [R12] double speed drops transmit divide to 8
// [R13] double speed receiver uses eight samples
// [R14] slave clock synchronised then edge detected
// [R15] slave clock kept below fclk over four
// [R16] pin outputs clock master, inputs slave
// [R17] sample on edge opposite to change
// [R18] polarity zero: change rising, sample falling
// [R19] software powers channel before use
`timescale 1ns/1ns
`default_nettype none
module ucg_clock_gen #(
    parameter int DIV_W = ucg_pkg::BAUD_DIV_W
) (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic xck_in, // transfer clock pin, input side
    output logic xck_out, // transfer clock pin, output side
    output logic xck_oe, // transfer clock pin, output enable
    output logic tx_clk, // transmitter bit strobe
    output logic rx_clk, // receiver base strobe
    output logic [3:0] rx_phase, // receiver recovery state
    output logic tx_change, // sync mode data change strobe
    output logic rx_sample // sync mode data sample strobe
);

    // ------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------
    if (DIV_W <= ucg_pkg::BAUD_LO_W || DIV_W > 16)
    begin : g_bad_width
        $error("divisor width must be 9 to 16 bits");
    end

    localparam int HI_W = DIV_W - ucg_pkg::BAUD_LO_W; // high byte width

    // ------------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------------

    // control bits to clock mode
    function automatic ucg_pkg::ucg_mode_e decode_mode(
        input logic [ucg_pkg::CTRL_W-1:0] c
    );
        if (!c[ucg_pkg::CTRL_SYNC_BIT]) // R2
        begin
            // double speed only counts when asynchronous
            decode_mode = c[ucg_pkg::CTRL_DOUBLE_BIT]
                ? ucg_pkg::UCG_ASYNC_DOUBLE
                : ucg_pkg::UCG_ASYNC_NORMAL; // R10
        end
        else if (c[ucg_pkg::CTRL_XCK_DIR_BIT])
        begin
            decode_mode = ucg_pkg::UCG_SYNC_MASTER; // R3
        end
        else
        begin
            decode_mode = ucg_pkg::UCG_SYNC_SLAVE; // R3
        end
    endfunction

    // clock mode to baud ticks per bit (also receiver phase count)
    function automatic logic [4:0] ticks_per_bit(
        input ucg_pkg::ucg_mode_e m
    );
        unique case (m)
            ucg_pkg::UCG_ASYNC_NORMAL: ticks_per_bit =
                ucg_pkg::DIV_ASYNC_NORMAL; // R7
            ucg_pkg::UCG_ASYNC_DOUBLE: ticks_per_bit =
                ucg_pkg::DIV_ASYNC_DOUBLE; // R12
            ucg_pkg::UCG_SYNC_MASTER: ticks_per_bit = ucg_pkg::DIV_SYNC;
            ucg_pkg::UCG_SYNC_SLAVE: ticks_per_bit = ucg_pkg::DIV_SYNC;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // register file and apb slave
    // ------------------------------------------------------------------
    logic [ucg_pkg::CTRL_W-1:0] ctrl; // mode and polarity bits
    logic [ucg_pkg::BAUD_LO_W-1:0] baud_lo; // divisor low byte
    logic [HI_W-1:0] baud_hi; // divisor high bits
    logic lo_reload; // pulse after a low byte write
    logic [ucg_pkg::CTRL_W-1:0] next_ctrl;
    logic [ucg_pkg::BAUD_LO_W-1:0] next_baud_lo;
    logic [HI_W-1:0] next_baud_hi;
    logic next_lo_reload;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [31:0] status_word; // read view of block state
    logic [DIV_W-1:0] baud_div; // joined divisor
    logic [DIV_W-1:0] baud_count; // live counter value
    logic baud_tick; // baud generator output
    logic setup_phase; // apb setup cycle
    logic write_done; // apb write completes this edge
    logic mapped; // address hits a register
    ucg_pkg::ucg_mode_e mode; // current clock mode
    logic xck_meta; // first pin stage, read only by second
    logic xck_sync; // second pin stage

    assign baud_div = {baud_hi, baud_lo}; // R9
    assign mode = decode_mode(ctrl); // R1
    assign setup_phase = psel && !penable;
    assign write_done = psel && penable && pready && pwrite;
    assign mapped = (paddr == ucg_pkg::ADDR_CTRL)
        || (paddr == ucg_pkg::ADDR_BAUD_LO)
        || (paddr == ucg_pkg::ADDR_BAUD_HI)
        || (paddr == ucg_pkg::ADDR_STATUS);

    // status: counter value, mode, pin levels
    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[DIV_W-1:0] = baud_count;
        status_word[ucg_pkg::STAT_MODE_LSB +: 2] = mode;
        status_word[ucg_pkg::STAT_XCK_IN_BIT] = xck_sync
            && (mode == ucg_pkg::UCG_SYNC_SLAVE); // R4
        status_word[ucg_pkg::STAT_XCK_OUT_BIT] = xck_out;
    end

    // register writes, read data capture, one-wait-free answer
    always_comb
    begin
        next_ctrl = ctrl;
        next_baud_lo = baud_lo;
        next_baud_hi = baud_hi;
        next_lo_reload = 1'b0;
        next_prdata = prdata;
        next_pready = setup_phase; // answer in first access cycle
        next_pslverr = setup_phase && !mapped;
        if (setup_phase && !pwrite)
        begin
            unique case (paddr)
                ucg_pkg::ADDR_CTRL: next_prdata =
                    {{(32-ucg_pkg::CTRL_W){1'b0}}, ctrl};
                ucg_pkg::ADDR_BAUD_LO: next_prdata =
                    {{(32-ucg_pkg::BAUD_LO_W){1'b0}}, baud_lo};
                ucg_pkg::ADDR_BAUD_HI: next_prdata =
                    {{(32-HI_W){1'b0}}, baud_hi};
                ucg_pkg::ADDR_STATUS: next_prdata = status_word;
                default: next_prdata = 32'h0000_0000; // unmapped
            endcase
        end
        if (write_done)
        begin
            unique case (paddr)
                ucg_pkg::ADDR_CTRL: next_ctrl =
                    pwdata[ucg_pkg::CTRL_W-1:0];
                ucg_pkg::ADDR_BAUD_LO:
                begin
                    next_baud_lo = pwdata[ucg_pkg::BAUD_LO_W-1:0];
                    next_lo_reload = 1'b1; // R5
                end
                ucg_pkg::ADDR_BAUD_HI: next_baud_hi = pwdata[HI_W-1:0];
                default: next_lo_reload = 1'b0; // status, unmapped
            endcase
        end
    end

    // register the bus state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= ucg_pkg::CTRL_RST;
            baud_lo <= ucg_pkg::BAUD_LO_RST;
            baud_hi <= '0;
            lo_reload <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            baud_lo <= next_baud_lo;
            baud_hi <= next_baud_hi;
            lo_reload <= next_lo_reload;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------------
    // baud rate generator
    // ------------------------------------------------------------------
    ucg_baud_gen #(
        .DIV_W(DIV_W)
    ) u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .divisor(baud_div),
        .reload(lo_reload),
        .tick(baud_tick),
        .count(baud_count)
    );

    // ------------------------------------------------------------------
    // external clock synchroniser and edge detector
    // ------------------------------------------------------------------
    logic xck_prev; // delayed copy for edges
    logic next_xck_meta;
    logic next_xck_sync;
    logic next_xck_prev;
    logic is_slave; // synchronous slave selected
    logic is_master; // synchronous master selected

    assign is_slave = (mode == ucg_pkg::UCG_SYNC_SLAVE);
    assign is_master = (mode == ucg_pkg::UCG_SYNC_MASTER);

    // pin passes two flops; its edges count only in slave mode
    always_comb
    begin
        next_xck_meta = xck_in; // R14
        next_xck_sync = xck_meta;
        next_xck_prev = xck_sync;
    end

    // register the synchroniser
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            xck_meta <= 1'b0;
            xck_sync <= 1'b0;
            xck_prev <= 1'b0;
        end
        else
        begin
            xck_meta <= next_xck_meta;
            xck_sync <= next_xck_sync;
            xck_prev <= next_xck_prev;
        end
    end

    // ------------------------------------------------------------------
    // transmitter and receiver clocks
    // ------------------------------------------------------------------
    logic [3:0] tx_div_cnt; // baud ticks into current bit
    logic [3:0] next_tx_div_cnt;
    logic [3:0] next_rx_phase;
    logic next_xck_out;
    logic next_xck_oe;
    logic next_tx_clk;
    logic next_rx_clk;
    logic next_tx_change;
    logic next_rx_sample;
    logic [4:0] bit_div; // ticks per bit for this mode
    logic rise_edge; // rising transfer clock event
    logic fall_edge; // falling transfer clock event
    logic change_edge; // edge on which output data changes
    logic sample_edge; // edge on which input data is taken
    logic pol; // polarity bit

    assign bit_div = ticks_per_bit(mode);
    assign pol = ctrl[ucg_pkg::CTRL_POL_BIT];

    // edges from own clock in master, from pin in slave
    always_comb
    begin
        rise_edge = 1'b0;
        fall_edge = 1'b0;
        if (is_master)
        begin
            rise_edge = baud_tick && !xck_out;
            fall_edge = baud_tick && xck_out;
        end
        else if (is_slave)
        begin
            rise_edge = xck_sync && !xck_prev; // R14
            fall_edge = !xck_sync && xck_prev; // R14
        end
        change_edge = pol ? fall_edge : rise_edge; // R18
        sample_edge = pol ? rise_edge : fall_edge; // R17 R18
    end

    // strobes, pin drive and receiver phase
    always_comb
    begin
        next_tx_div_cnt = tx_div_cnt;
        next_tx_clk = 1'b0;
        next_rx_clk = 1'b0;
        next_rx_phase = rx_phase;
        next_xck_oe = is_master; // R16
        next_xck_out = 1'b0; // R4
        next_tx_change = change_edge;
        next_rx_sample = sample_edge;
        if (is_master)
        begin
            // pin toggles each tick: one period per two ticks
            next_xck_out = baud_tick ? !xck_out : xck_out; // R16
        end
        if (mode == ucg_pkg::UCG_ASYNC_NORMAL
            || mode == ucg_pkg::UCG_ASYNC_DOUBLE)
        begin
            if (baud_tick)
            begin
                if ({1'b0, tx_div_cnt} == bit_div - 5'h01)
                begin
                    next_tx_div_cnt = 4'h0;
                    next_tx_clk = 1'b1; // R7 R12
                end
                else
                begin
                    next_tx_div_cnt = tx_div_cnt + 4'h1;
                end
            end
        end
        else
        begin
            // one change edge per transfer clock period
            next_tx_div_cnt = 4'h0;
            next_tx_clk = change_edge; // R7
        end
        // receiver base: undivided tick, or pin edges in slave
        next_rx_clk = is_slave ? (rise_edge || fall_edge) : baud_tick;
        if ({1'b0, rx_phase} >= bit_div)
        begin
            next_rx_phase = 4'h0; // mode changed under it
        end
        else if (next_rx_clk)
        begin
            if ({1'b0, rx_phase} == bit_div - 5'h01)
            begin
                next_rx_phase = 4'h0; // R8 R13
            end
            else
            begin
                next_rx_phase = rx_phase + 4'h1; // R8
            end
        end
    end

    // register clock outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_div_cnt <= 4'h0;
            rx_phase <= 4'h0;
            xck_out <= 1'b0;
            xck_oe <= 1'b0;
            tx_clk <= 1'b0;
            rx_clk <= 1'b0;
            tx_change <= 1'b0;
            rx_sample <= 1'b0;
        end
        else
        begin
            tx_div_cnt <= next_tx_div_cnt;
            rx_phase <= next_rx_phase;
            xck_out <= next_xck_out;
            xck_oe <= next_xck_oe;
            tx_clk <= next_tx_clk;
            rx_clk <= next_rx_clk;
            tx_change <= next_tx_change;
            rx_sample <= next_rx_sample;
        end
    end

endmodule
`default_nettype wire

// ==== design/ucg_pkg.sv ====
// ----------------------------------------------------------------------
// shared constants of the serial clock generation unit
// ----------------------------------------------------------------------
package ucg_pkg;

    // apb byte addresses of the register map
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_BAUD_LO = 12'h004;
    localparam logic [11:0] ADDR_BAUD_HI = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00c;

    // control register fields
    localparam int CTRL_W = 4;
    localparam int CTRL_SYNC_BIT = 0;
    localparam int CTRL_DOUBLE_BIT = 1;
    localparam int CTRL_XCK_DIR_BIT = 2;
    localparam int CTRL_POL_BIT = 3;
    localparam logic [3:0] CTRL_RST = 4'h0;

    // baud divisor layout and reset value
    localparam int BAUD_DIV_W = 12;
    localparam int BAUD_LO_W = 8;
    localparam logic [7:0] BAUD_LO_RST = 8'h00;

    // status register fields
    localparam int STAT_MODE_LSB = 12;
    localparam int STAT_XCK_IN_BIT = 14;
    localparam int STAT_XCK_OUT_BIT = 15;

    // baud ticks per transmitter bit, and receiver phases per bit
    localparam logic [4:0] DIV_ASYNC_NORMAL = 5'h10;
    localparam logic [4:0] DIV_ASYNC_DOUBLE = 5'h08;
    localparam logic [4:0] DIV_SYNC = 5'h02;

    // the four clock modes
    typedef enum logic [1:0] {
        UCG_ASYNC_NORMAL,
        UCG_ASYNC_DOUBLE,
        UCG_SYNC_MASTER,
        UCG_SYNC_SLAVE
    } ucg_mode_e;

endpackage

// ==== verification/test_usart_clock_generation.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_usart_clock_generation;
    logic pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, xck_out, xck_oe, tx_clk, rx_clk;
    logic tx_change, rx_sample, rem_xck, xck_in, err;
    logic [3:0] rx_phase, c;
    int bad_count, compares, cyc, n_rx, n_tc, n_rs, p, d, b0, b1, b2;
    // pin level: unit drives when enabled, else the remote side
    assign xck_in = xck_oe ? xck_out : rem_xck;
    ucg_clock_gen DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .xck_in(xck_in), .xck_out(xck_out),
        .xck_oe(xck_oe), .tx_clk(tx_clk), .rx_clk(rx_clk),
        .rx_phase(rx_phase), .tx_change(tx_change),
        .rx_sample(rx_sample));
    ucg_remote_xcvr u_rem (.pclk(pclk), .xck(rem_xck));
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // strobe counters and hang guard
    always @(posedge pclk)
    begin
        cyc++;
        if (rx_clk === 1'b1) n_rx++;
        if (tx_change === 1'b1) n_tc++;
        if (rx_sample === 1'b1) n_rs++;
        if (cyc == 40000)
        begin
            bad_count++;
            $display("ERROR %0t run timed out", $time);
            end_sim();
        end
    end
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // cycles between two pulses of tx_clk or rx_clk
    task automatic per(input bit r, output int q);
        int n;
        n = 0;
        q = 0;
        @(negedge pclk);
        while ((r ? rx_clk : tx_clk) !== 1'b1 && n < 9000)
        begin
            @(negedge pclk);
            n++;
        end
        do
        begin
            @(negedge pclk);
            q++;
        end
        while ((r ? rx_clk : tx_clk) !== 1'b1 && q < 9000);
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        d = $urandom(73112);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ucg_pkg::ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, ucg_pkg::ADDR_BAUD_LO, 32'h0);
        chk(rd, 32'h0);
        chk(xck_oe, 1'b0);
        apb(1'b0, 12'h010, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, ucg_pkg::ADDR_BAUD_HI, 32'hffffffff);
        apb(1'b0, ucg_pkg::ADDR_BAUD_HI, 32'h0);
        chk(rd, 32'h0000000f);
        $display("test reset and registers done");
        // async normal, double, master, master with double set
        for (int m = 0; m < 4; m++)
        begin
            d = (m == 0) ? 0 : $urandom % 8;
            c = (m == 0) ? 4'h0 : (m == 1) ? 4'h2 : (m == 2) ? 4'h5 : 4'h7;
            if (m > 1) c[3] = $urandom % 2;
            apb(1'b1, ucg_pkg::ADDR_BAUD_HI, 32'(d >> 8));
            apb(1'b1, ucg_pkg::ADDR_BAUD_LO, 32'(d & 255));
            apb(1'b1, ucg_pkg::ADDR_CTRL, 32'(c));
            repeat (4) @(posedge pclk);
            per(1'b0, p);
            b2 = (m == 0 ? 16 : m == 1 ? 8 : 2) * (d + 1);
            chk(32'(p), 32'(b2));
            per(1'b1, p);
            chk(32'(p), 32'(d + 1));
            chk(xck_oe, c[0]);
            apb(1'b0, ucg_pkg::ADDR_STATUS, 32'h0);
            chk(rd[13:12], (m < 2) ? m : 2);
            $display("test mode %0d divisor %0d done", m, d);
        end
        // repeated low writes keep the counter from wrapping
        apb(1'b1, ucg_pkg::ADDR_CTRL, 32'h0);
        apb(1'b1, ucg_pkg::ADDR_BAUD_HI, 32'h0);
        apb(1'b1, ucg_pkg::ADDR_BAUD_LO, 32'd40);
        repeat (4) @(posedge pclk);
        b0 = n_rx;
        repeat (10) apb(1'b1, ucg_pkg::ADDR_BAUD_LO, 32'd40);
        chk(32'(n_rx - b0), 32'h0);
        // remote clock toggling is ignored in async mode
        apb(1'b1, ucg_pkg::ADDR_BAUD_LO, 32'h0);
        b1 = n_tc + n_rs;
        u_rem.burst(6, 3);
        repeat (4) @(posedge pclk);
        chk(32'(n_tc + n_rs - b1), 32'h0);
        $display("test reload and async pin done");
        // slave mode: every synced pin edge becomes a strobe
        apb(1'b1, ucg_pkg::ADDR_CTRL, 32'h1 | 32'(($urandom % 2) << 3));
        repeat (10) @(posedge pclk);
        {b0, b1, b2} = {n_rx, n_tc, n_rs};
        u_rem.burst(6, 3 + $urandom % 3);
        repeat (6) @(posedge pclk);
        chk(32'(n_rx - b0), 32'h6);
        chk(32'(n_tc - b1), 32'h3);
        chk(32'(n_rs - b2), 32'h3);
        chk(xck_oe, 1'b0);
        $display("test slave mode done");
        end_sim();
    end
endmodule
bind ucg_clock_gen ucg_clock_gen_assertions u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .xck_in(xck_in), .xck_out(xck_out),
    .xck_oe(xck_oe), .tx_clk(tx_clk), .rx_clk(rx_clk),
    .rx_phase(rx_phase), .tx_change(tx_change), .rx_sample(rx_sample));
`default_nettype wire

// ==== verification/ucg_clock_gen_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------
// port checker of the clock generation unit
// ----------------------------------------------------------------------
module ucg_clock_gen_assertions (
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire logic psel, // select
    input wire logic penable, // enable
    input wire logic pwrite, // direction
    input wire logic [11:0] paddr, // address
    input wire logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic xck_in, // pin in
    input wire logic xck_out, // pin out
    input wire logic xck_oe, // pin enable
    input wire logic tx_clk, // tx strobe
    input wire logic rx_clk, // rx strobe
    input wire logic [3:0] rx_phase, // rx state
    input wire logic tx_change, // change strobe
    input wire logic rx_sample // sample strobe
);
    logic [3:0] ctl; // control shadow
    logic [11:0] dv; // divisor shadow
    logic [15:0] st; // cycles since config write
    logic [15:0] tg; // cycles since tx_clk
    logic [15:0] rg; // cycles since rx_clk
    logic wr; // write lands this edge
    logic [31:0] ratio; // ticks per tx bit
    logic mst; // master mode
    logic slv; // slave mode
    logic hit; // address names a register
    assign wr = psel && penable && pready && pwrite;
    assign hit = paddr inside {ucg_pkg::ADDR_CTRL, ucg_pkg::ADDR_BAUD_LO,
        ucg_pkg::ADDR_BAUD_HI, ucg_pkg::ADDR_STATUS};
    assign mst = ctl[0] && ctl[2];
    assign slv = ctl[0] && !ctl[2];
    assign ratio = ctl[0] ? 32'h2 : (ctl[1] ? 32'h8 : 32'h10);
    // shadows follow the bus, counters measure strobe spacing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl <= 4'h0;
            dv <= 12'h000;
            st <= 16'h0000;
            tg <= 16'h0000;
            rg <= 16'h0000;
        end
        else
        begin
            if (wr && paddr == ucg_pkg::ADDR_CTRL)
                ctl <= pwdata[3:0];
            if (wr && paddr == ucg_pkg::ADDR_BAUD_LO)
                dv[7:0] <= pwdata[7:0];
            if (wr && paddr == ucg_pkg::ADDR_BAUD_HI)
                dv[11:8] <= pwdata[3:0];
            if (wr && paddr < ucg_pkg::ADDR_STATUS)
                st <= 16'h0000;
            else if (st != 16'hffff)
                st <= st + 16'h0001;
            tg <= tx_clk ? 16'h0001 : (tg == 16'hffff ? tg : tg + 16'h0001);
            rg <= rx_clk ? 16'h0001 : (rg == 16'hffff ? rg : rg + 16'h0001);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    zero_wait_a: assert property ($rose(penable) && psel |-> pready)
        else $error("access not answered at once");
    unmapped_err_a: assert property (pready |-> pslverr == !hit)
        else $error("slave error wrong");
    phase_range_a: assert property (st > 2 |-> 32'(rx_phase) < ratio)
        else $error("rx phase out of range");
    phase_step_a: assert property (rx_clk && st > 3 |->
        32'(rx_phase) == (32'($past(rx_phase)) + 1) % ratio)
        else $error("rx phase step wrong");
    async_idle_a: assert property (!ctl[0] && st > 2 |->
        !xck_oe && !tx_change && !rx_sample)
        else $error("pin used in async mode");
    pin_direction_a: assert property (ctl[0] && st > 2 |-> xck_oe == ctl[2])
        else $error("pin direction wrong");
    change_edge_a: assert property (mst && st > 4 && tx_change |->
        $changed(xck_out) && xck_out == !ctl[3])
        else $error("change on wrong edge");
    sample_edge_a: assert property (mst && st > 4 && rx_sample |->
        $changed(xck_out) && xck_out == ctl[3] && !tx_change)
        else $error("sample on wrong edge");
    tx_period_a: assert property (tx_clk && !slv && st > tg + 4 |->
        32'(tg) == ratio * (32'(dv) + 1))
        else $error("tx bit period wrong");
    baud_period_a: assert property (rx_clk && !slv && st > rg + 4 |->
        32'(rg) == 32'(dv) + 1)
        else $error("baud period wrong");
    slave_delay_a: assert property (slv && st > 8 && $changed(xck_in) |->
        ##3 rx_clk)
        else $error("slave edge latency wrong");
    cover property (mst && tx_change);
    cover property (slv && rx_sample);
    cover property (!ctl[0] && ctl[1] && tx_clk);
    cover property (pslverr);
endmodule
`default_nettype wire

// ==== verification/ucg_remote_xcvr.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------
// remote transceiver: drives the transfer clock in bursts
// ----------------------------------------------------------------------
module ucg_remote_xcvr (
    input wire logic pclk, // bench clock
    output logic xck // clock toward the unit
);
    initial xck = 1'b0;
    // burst of edges, clock stands still afterwards
    task automatic burst(input int edges, input int half);
        for (int i = 0; i < edges; i++)
        begin
            repeat (half) @(posedge pclk);
            xck <= ~xck;
        end
    endtask
endmodule
`default_nettype wire
